/* hdl/abam_consts.svh */
`ifndef ABAM_CONSTS_SVH
`define ABAM_CONSTS_SVH

// field positions shared by both formats
`define ABAM_BASE_HI 31
`define ABAM_BASE_LO 24
`define ABAM_MASK_HI 23
`define ABAM_MASK_LO 16
`define ABAM_ON_BIT 15
// older format fields
`define ABAM_O_NOCACHE_BIT 10
`define ABAM_O_DIRSEL_BIT 9
`define ABAM_O_DIRIGN_BIT 8
`define ABAM_O_SCM_HI 6
`define ABAM_O_SCM_LO 4
`define ABAM_O_SCI_HI 2
`define ABAM_O_SCI_LO 0
// newer format fields
`define ABAM_N_PRIV_HI 14
`define ABAM_N_PRIV_LO 13
`define ABAM_N_UATTR1_BIT 9
`define ABAM_N_UATTR0_BIT 8
`define ABAM_N_CPOL_HI 6
`define ABAM_N_CPOL_LO 5
`define ABAM_N_GUARD_BIT 2
// status bit set by a probe hit
`define ABAM_STATUS_HIT_BIT 6
// reset values
`define ABAM_BLOCK_RESET 32'h0000_0000
`define ABAM_SPACE_RESET 3'h0
`define ABAM_STATUS_RESET 16'h0000

`endif

/* hdl/abam_match.sv */
`timescale 1ns/100ps
`default_nettype none
`include "abam_consts.svh"

module abam_match
    import abam_pkg::*;
#(
    parameter int NBLK = 2
)(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // register side: the core only raises these strobes while running a
    // privileged move, but the mode line is still checked here so that a
    // stray strobe from user code can never reconfigure a block
    // privileged register access from the core
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire abam_sel_t reg_sel_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic super_mode_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_priv_err_o,
    // access side: one access per cycle at most, all qualifiers valid in
    // the same cycle as acc_valid_i; nothing here is held or queued, so
    // the address path must keep these lines steady for that one cycle
    // access presented by the address path
    input wire logic acc_valid_i,
    input wire logic [31:0] acc_addr_i,
    input wire logic [2:0] acc_fc_i,
    input wire logic acc_read_i,
    input wire logic acc_rmw_i,
    input wire logic acc_newfmt_i,
    input wire logic acc_ext_bus_i,
    // probe request for an address and function code
    input wire logic probe_instr_i,
    // result side: every result is a flop, so the address path sees the
    // verdict for an access exactly one cycle later; a miss or an idle
    // cycle leaves every result at zero except the two space codes, which keep their stored values
    // results, registered one cycle after the access
    output logic match_o,
    output logic [31:0] phys_addr_o,
    output logic phys_valid_o,
    output logic no_cache_o,
    output logic [1:0] cache_policy_o,
    output logic abort_o,
    output logic page_attr_out0_o,
    output logic page_attr_out1_o,
    output logic [2:0] src_space_code_o,
    output logic [2:0] dst_space_code_o
);

    // register store
    // the two formats keep separate block registers; an access names the
    // format it wants, so both sets can be loaded side by side and the
    // core picks one per access without reprogramming anything
    // all registers clear to zero, which leaves every block switched off
    // until supervisor software has written it
    // the space codes are only stored and shown; the address path reads
    // them itself when a designated instruction asks for an alternate space
    // block registers, two per format
    logic [31:0] old_blk [NBLK];
    logic [31:0] new_blk [NBLK];
    logic [31:0] next_old_blk [NBLK];
    logic [31:0] next_new_blk [NBLK];
    logic [2:0] src_space_code; // alternate source function code
    logic [2:0] dst_space_code; // alternate destination function code
    logic [2:0] next_src_space_code;
    logic [2:0] next_dst_space_code;
    logic [15:0] attr_match_status; // only the hit bit is meaningful
    logic [15:0] next_attr_match_status;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic priv_err;
    logic next_priv_err;

    // one hit bit per block and format; these are pure combinational
    // functions of the current access and the stored registers, so a
    // register write only affects accesses from the next cycle onwards
    // per-block match results
    logic [NBLK-1:0] old_hit;
    logic [NBLK-1:0] new_hit;

    // block compare
    // each block compares the top address byte against its base, with
    // mask bits knocking single bits out of the compare, so one register
    // can cover any power-of-two multiple of a 16 Mbyte region
    // the older format adds a function code compare and a direction test;
    // the newer format only looks at the supervisor bit of the code
    // both compares are built for every block even though an access uses
    // one format; the cost is a few gates and it keeps the probe simple
    // match logic per block, same shape for each register pair
    genvar g;
    generate
        for (g = 0; g < NBLK; g++)
        begin : gen_blk
            logic [7:0] o_amask;
            logic [7:0] n_amask;
            logic o_addr_ok;
            logic n_addr_ok;
            logic o_fc_ok;
            logic o_dir_ok;
            logic n_priv_ok;
            logic [2:0] o_sci;
            logic [1:0] n_priv;
            assign o_amask = old_blk[g][`ABAM_MASK_HI:`ABAM_MASK_LO];
            assign n_amask = new_blk[g][`ABAM_MASK_HI:`ABAM_MASK_LO];
            // xor finds the differing bits, the inverted mask keeps only
            // the bits that must agree; a zero result is a match
            // a mask of all ones matches the whole 4 Gbyte space
            // masked bits never take part in the compare
            assign o_addr_ok = ((acc_addr_i[31:24] ^ old_blk[g][`ABAM_BASE_HI:`ABAM_BASE_LO])
                & ~o_amask) == 8'h00;
            assign n_addr_ok = ((acc_addr_i[31:24] ^ new_blk[g][`ABAM_BASE_HI:`ABAM_BASE_LO])
                & ~n_amask) == 8'h00;
            assign o_sci = old_blk[g][`ABAM_O_SCI_HI:`ABAM_O_SCI_LO];
            assign o_fc_ok = ((acc_fc_i ^ old_blk[g][`ABAM_O_SCM_HI:`ABAM_O_SCM_LO])
                & ~o_sci) == 3'h0;
            // a read-modify-write counts as a read here; the guard logic
            // below is what treats its write half separately
            // dir_select 1 means reads only, 0 writes only
            assign o_dir_ok = old_blk[g][`ABAM_O_DIRIGN_BIT]
                || (old_blk[g][`ABAM_O_DIRSEL_BIT] == acc_read_i);
            assign n_priv = new_blk[g][`ABAM_N_PRIV_HI:`ABAM_N_PRIV_LO];
            assign n_priv_ok = n_priv[1] || (n_priv[0] == acc_fc_i[2]);
            // enabled and every unmasked condition agrees
            assign old_hit[g] = old_blk[g][`ABAM_ON_BIT] && o_addr_ok
                && o_fc_ok && o_dir_ok;
            assign new_hit[g] = new_blk[g][`ABAM_ON_BIT] && n_addr_ok
                && n_priv_ok;
        end
    endgenerate

    // attribute selection
    // overlapping blocks are legal, so a fixed priority is needed: the
    // loop walks from the highest index down and lets each later hit
    // overwrite the earlier one, which leaves the lowest index in charge
    // the older format has no user attribute or guard bits, so those stay
    // at zero for it and its policy is derived from the no-cache flag
    // defaults cover the miss case so that nothing is latched
    // attribute selection; lowest matching block wins
    logic hit;
    logic a_nc;
    logic [1:0] a_cpol;
    logic a_abort;
    logic a_u0;
    logic a_u1;
    logic probe_hit;
    always_comb
    begin
        hit = 1'b0;
        a_nc = 1'b0;
        a_cpol = ABAM_CP_WTHRU;
        a_abort = 1'b0;
        a_u0 = 1'b0;
        a_u1 = 1'b0;
        for (int i = NBLK - 1; i >= 0; i--)
        begin
            if (acc_newfmt_i && new_hit[i])
            begin
                hit = 1'b1;
                a_cpol = new_blk[i][`ABAM_N_CPOL_HI:`ABAM_N_CPOL_LO];
                a_nc = a_cpol[1];
                // writes and rmw abort, reads pass
                a_abort = new_blk[i][`ABAM_N_GUARD_BIT]
                    && (!acc_read_i || acc_rmw_i);
                a_u0 = new_blk[i][`ABAM_N_UATTR0_BIT];
                a_u1 = new_blk[i][`ABAM_N_UATTR1_BIT];
            end
            else if (!acc_newfmt_i && old_hit[i])
            begin
                hit = 1'b1;
                a_nc = old_blk[i][`ABAM_O_NOCACHE_BIT];
                a_cpol = a_nc ? ABAM_CP_NC : ABAM_CP_WTHRU;
                a_abort = 1'b0;
                a_u0 = 1'b0;
                a_u1 = 1'b0;
            end
        end
        // the probe reuses the access compare, so the caller presents the
        // probed address, code and direction on the access lines; it does
        // not need acc_valid_i and so never produces a result pulse itself
        // probe uses the format selected by the caller
        probe_hit = acc_newfmt_i ? (|new_hit) : (|old_hit);
    end

    // result staging
    // every result is gated by acc_valid_i and the hit, so an idle cycle
    // or a miss drives all zeros; the address path can then treat a zero
    // physical-valid as "use the paged translation instead"
    // the physical address is the logical one unchanged on a hit; no
    // offset or relocation exists in this block by design
    // result registers
    logic next_match;
    logic [31:0] next_phys_addr;
    logic next_phys_valid;
    logic next_no_cache;
    logic [1:0] next_cache_policy;
    logic next_abort;
    logic next_pa0;
    logic next_pa1;
    always_comb
    begin
        next_match = acc_valid_i && hit;
        // identity mapping bypasses any paged translation
        next_phys_addr = (acc_valid_i && hit) ? acc_addr_i : 32'h0000_0000;
        next_phys_valid = acc_valid_i && hit;
        next_no_cache = acc_valid_i && hit && a_nc;
        next_cache_policy = (acc_valid_i && hit) ? a_cpol : ABAM_CP_WTHRU;
        next_abort = acc_valid_i && hit && a_abort;
        // attribute pins only move for external bus transfers
        next_pa0 = acc_valid_i && hit && acc_ext_bus_i && a_u0;
        next_pa1 = acc_valid_i && hit && acc_ext_bus_i && a_u1;
    end

    // register file
    // a write and a read in the same cycle resolve as a write; the core
    // never issues both, and giving one of them priority avoids a mux
    // fight on the select lines
    // read data is a flop that holds its value until the next accepted
    // read, so a late sample of the read bus still sees the same word
    // status is read-only: a write to its select is dropped quietly
    // register file writes, probe status and read data
    always_comb
    begin
        for (int i = 0; i < NBLK; i++)
        begin
            next_old_blk[i] = old_blk[i];
            next_new_blk[i] = new_blk[i];
        end
        next_src_space_code = src_space_code;
        next_dst_space_code = dst_space_code;
        next_attr_match_status = attr_match_status;
        next_rdata = rdata;
        next_priv_err = 1'b0;
        // the error flag is a one-cycle pulse; the core turns it into a
        // privilege trap, so it must not stay high past the offending cycle
        // user-mode accesses are refused and flagged, nothing changes
        if ((reg_wr_i || reg_rd_i) && !super_mode_i)
        begin
            next_priv_err = 1'b1;
        end
        else if (reg_wr_i)
        begin
            if (reg_sel_i == ABAM_SEL_OLD0)
                next_old_blk[0] = reg_wdata_i;
            else if (reg_sel_i == ABAM_SEL_OLD1)
                next_old_blk[NBLK-1] = reg_wdata_i;
            else if (reg_sel_i == ABAM_SEL_NEW0)
                next_new_blk[0] = reg_wdata_i;
            else if (reg_sel_i == ABAM_SEL_NEW1)
                next_new_blk[NBLK-1] = reg_wdata_i;
            else if (reg_sel_i == ABAM_SEL_SRC)
                next_src_space_code = reg_wdata_i[2:0];
            else if (reg_sel_i == ABAM_SEL_DST)
                next_dst_space_code = reg_wdata_i[2:0];
        end
        else if (reg_rd_i)
        begin
            if (reg_sel_i == ABAM_SEL_OLD0)
                next_rdata = old_blk[0];
            else if (reg_sel_i == ABAM_SEL_OLD1)
                next_rdata = old_blk[NBLK-1];
            else if (reg_sel_i == ABAM_SEL_NEW0)
                next_rdata = new_blk[0];
            else if (reg_sel_i == ABAM_SEL_NEW1)
                next_rdata = new_blk[NBLK-1];
            else if (reg_sel_i == ABAM_SEL_SRC)
                next_rdata = {29'h0000_0000, src_space_code};
            else if (reg_sel_i == ABAM_SEL_DST)
                next_rdata = {29'h0000_0000, dst_space_code};
            else if (reg_sel_i == ABAM_SEL_STATUS)
                next_rdata = {16'h0000, attr_match_status};
            else
                next_rdata = 32'h0000_0000;
        end
        // software is only allowed to trust the hit bit, so clearing the
        // rest costs nothing and keeps reads repeatable across probes
        // a user-mode probe is ignored without any error pulse
        // probe replaces the whole status; other bits read zero
        if (probe_instr_i && super_mode_i)
        begin
            next_attr_match_status = `ABAM_STATUS_RESET;
            next_attr_match_status[`ABAM_STATUS_HIT_BIT] = probe_hit;
        end
    end

    // state update
    // one clocked process holds every flop of the block; it only copies
    // the next values computed above, so all decisions live in the
    // combinational processes and the flops stay simple to check
    // reset is synchronous, so a reset pulse must span at least one edge;
    // outputs are zero during reset and stay zero until the first edge after release
    // state registers, synchronous active-low reset
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            for (int i = 0; i < NBLK; i++)
            begin
                old_blk[i] <= `ABAM_BLOCK_RESET;
                new_blk[i] <= `ABAM_BLOCK_RESET;
            end
            src_space_code <= `ABAM_SPACE_RESET;
            dst_space_code <= `ABAM_SPACE_RESET;
            attr_match_status <= `ABAM_STATUS_RESET;
            rdata <= 32'h0000_0000;
            priv_err <= 1'b0;
            match_o <= 1'b0;
            phys_addr_o <= 32'h0000_0000;
            phys_valid_o <= 1'b0;
            no_cache_o <= 1'b0;
            cache_policy_o <= ABAM_CP_WTHRU;
            abort_o <= 1'b0;
            page_attr_out0_o <= 1'b0;
            page_attr_out1_o <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NBLK; i++)
            begin
                old_blk[i] <= next_old_blk[i];
                new_blk[i] <= next_new_blk[i];
            end
            src_space_code <= next_src_space_code;
            dst_space_code <= next_dst_space_code;
            attr_match_status <= next_attr_match_status;
            rdata <= next_rdata;
            priv_err <= next_priv_err;
            match_o <= next_match;
            phys_addr_o <= next_phys_addr;
            phys_valid_o <= next_phys_valid;
            no_cache_o <= next_no_cache;
            cache_policy_o <= next_cache_policy;
            abort_o <= next_abort;
            page_attr_out0_o <= next_pa0;
            page_attr_out1_o <= next_pa1;
        end
    end

    // register-side outputs come straight from flops; the space codes are
    // shown permanently so the address path can pick them up without a
    // read cycle when an alternate-space instruction runs
    // read data and the error pulse are flops as well
    assign reg_rdata_o = rdata;
    assign reg_priv_err_o = priv_err;
    assign src_space_code_o = src_space_code;
    assign dst_space_code_o = dst_space_code;

endmodule : abam_match
`default_nettype wire

/* hdl/abam_pkg.sv */
package abam_pkg;
    // selects which register a control access reaches
    typedef enum logic [2:0] {
        ABAM_SEL_OLD0 = 3'b000,
        ABAM_SEL_OLD1 = 3'b001,
        ABAM_SEL_NEW0 = 3'b010,
        ABAM_SEL_NEW1 = 3'b011,
        ABAM_SEL_SRC = 3'b100,
        ABAM_SEL_DST = 3'b101,
        ABAM_SEL_STATUS = 3'b110
    } abam_sel_t;

    // handling of a matched access
    typedef enum logic [1:0] {
        ABAM_CP_WTHRU = 2'b00,
        ABAM_CP_COPYBACK = 2'b01,
        ABAM_CP_NC_SERIAL = 2'b10,
        ABAM_CP_NC = 2'b11
    } abam_cpol_t;
endpackage : abam_pkg

/* sim/abam_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// core address path stand-in; idle lines show the inverse of the last
// value so a stale address can never pass for a fresh one
module abam_core_model (
    input wire logic core_clk_i,
    input wire logic go_i,
    input wire logic [31:0] addr_i,
    input wire logic [2:0] fc_i,
    output logic acc_valid_o,
    output logic [31:0] acc_addr_o,
    output logic [2:0] acc_fc_o
);
    logic [31:0] last = 32'h0; // address seen at the last edge
    // remember the lines at each edge
    always @(posedge core_clk_i)
        last <= acc_addr_o;
    assign acc_valid_o = go_i;
    assign acc_addr_o = go_i ? addr_i : ~last;
    assign acc_fc_o = go_i ? fc_i : ~fc_i;
endmodule : abam_core_model
`default_nettype wire

/* sim/abam_match_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// port-level checks on the block attribute matcher
module abam_match_monitor
    import abam_pkg::*;
#(
    parameter int NBLK = 2
)(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire abam_sel_t reg_sel_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic super_mode_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic reg_priv_err_o,
    input wire logic acc_valid_i,
    input wire logic [31:0] acc_addr_i,
    input wire logic acc_read_i,
    input wire logic acc_rmw_i,
    input wire logic acc_newfmt_i,
    input wire logic acc_ext_bus_i,
    input wire logic match_o,
    input wire logic [31:0] phys_addr_o,
    input wire logic phys_valid_o,
    input wire logic no_cache_o,
    input wire logic [1:0] cache_policy_o,
    input wire logic abort_o,
    input wire logic page_attr_out0_o,
    input wire logic [2:0] src_space_code_o,
    input wire logic [2:0] dst_space_code_o
);
    // one clock domain, so one default clock and reset
    default clocking mon_cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    phys_pass_a: assert property (match_o |-> phys_addr_o == $past(acc_addr_i))
        else $error("physical address differs from logical address");
    miss_zero_a: assert property (!match_o |-> phys_addr_o == 32'h0 && !abort_o)
        else $error("miss left results set");
    hit_cause_a: assert property (match_o |-> $past(acc_valid_i) && phys_valid_o)
        else $error("match without an access");
    nocache_pol_a: assert property (no_cache_o == (match_o && cache_policy_o[1]))
        else $error("cache flag disagrees with policy");
    guard_dir_a: assert property (abort_o |-> $past(acc_newfmt_i) && (!$past(acc_read_i) || $past(acc_rmw_i)))
        else $error("abort on a plain read");
    attr_bus_a: assert property (page_attr_out0_o |-> match_o && $past(acc_ext_bus_i))
        else $error("page attribute without bus transfer");
    priv_err_a: assert property ((reg_wr_i || reg_rd_i) && !super_mode_i |=> reg_priv_err_o)
        else $error("user access not flagged");
    user_wr_a: assert property (reg_wr_i && !super_mode_i |=> $stable(src_space_code_o) && $stable(dst_space_code_o))
        else $error("user write changed a space code");
    src_load_a: assert property (reg_wr_i && super_mode_i && reg_sel_i == ABAM_SEL_SRC |=> src_space_code_o == 3'($past(reg_wdata_i)))
        else $error("source space code not loaded");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
endmodule : abam_match_monitor
bind abam_match abam_match_monitor #(.NBLK(NBLK)) u_mon (.core_clk_i, .nrst_i, .reg_wr_i,
    .reg_rd_i, .reg_sel_i, .reg_wdata_i, .super_mode_i, .reg_rdata_o, .reg_priv_err_o,
    .acc_valid_i, .acc_addr_i, .acc_read_i, .acc_rmw_i, .acc_newfmt_i, .acc_ext_bus_i,
    .match_o, .phys_addr_o, .phys_valid_o, .no_cache_o, .cache_policy_o, .abort_o,
    .page_attr_out0_o, .src_space_code_o, .dst_space_code_o);
`default_nettype wire

/* sim/address_block_attr_match_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module address_block_attr_match_bench import abam_pkg::*;;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, sup = 1'b1, go = 1'b0, rw = 1'b0;
    logic rmw = 1'b0, nf = 1'b0, ext = 1'b0, pr = 1'b0, av, mt, pv, nc, ab, p0, p1, perr;
    abam_sel_t sel = ABAM_SEL_OLD0;
    logic [31:0] wd = 32'h0, a = 32'h0, aa, rdat, phys, sh [8]; // sh mirrors registers
    logic [2:0] fc = 3'h0, afc, srcc, dstc;
    logic [1:0] pol;
    int error_cnt = 0, checks = 0;
    // top bytes near block edges; old0 hits fc 5 reads, new0 is guarded
    logic [7:0] tb [8] = '{8'h12, 8'h13, 8'h40, 8'h7f, 8'h80, 8'h8f, 8'h90, 8'hc0};
    logic [31:0] cfg [4] = '{32'h1200_8650, 32'h403f_8107, 32'h800f_a324, 32'h0};
    always #4 clk = ~clk;
    abam_match dut (.core_clk_i(clk), .nrst_i(nrst), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_sel_i(sel), .reg_wdata_i(wd), .super_mode_i(sup), .reg_rdata_o(rdat),
        .reg_priv_err_o(perr), .acc_valid_i(av), .acc_addr_i(aa), .acc_fc_i(afc),
        .acc_read_i(rw), .acc_rmw_i(rmw), .acc_newfmt_i(nf), .acc_ext_bus_i(ext),
        .probe_instr_i(pr), .match_o(mt), .phys_addr_o(phys), .phys_valid_o(pv),
        .no_cache_o(nc), .cache_policy_o(pol), .abort_o(ab), .page_attr_out0_o(p0),
        .page_attr_out1_o(p1), .src_space_code_o(srcc), .dst_space_code_o(dstc));
    abam_core_model core (.core_clk_i(clk), .go_i(go), .addr_i(a), .fc_i(fc),
        .acc_valid_o(av), .acc_addr_o(aa), .acc_fc_o(afc));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task give_verdict;
        if (error_cnt == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // one write strobe; the status register is read-only
    task wreg(input abam_sel_t s, input logic [31:0] d);
        sel = s;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        chk(64'(perr), 64'(!sup));
        if (sup && s < ABAM_SEL_STATUS)
            sh[s] = s[2] ? {29'h0, d[2:0]} : d;
    endtask : wreg
    // only the hit bit of the status is trusted
    task rreg(input abam_sel_t s);
        logic [31:0] m;
        m = (s == ABAM_SEL_STATUS) ? 32'h40 : 32'hffff_ffff;
        sel = s;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(64'(rdat & m), 64'(sh[s] & m));
    endtask : rreg
    function automatic logic hit(logic [31:0] r, x, logic [2:0] f, logic d, n);
        return r[15] && (((x[31:24] ^ r[31:24]) & ~r[23:16]) == 8'h00) && (n ?
            (r[14] || r[13] == f[2]) : (((f ^ r[6:4]) & ~r[2:0]) == 3'h0 && (r[8] || r[9] == d)));
    endfunction : hit
    // lowest-index hit of the selected format supplies the attributes
    function automatic logic [38:0] expo(logic [31:0] x, logic [2:0] f, logic d, m, n, e);
        logic [31:0] r;
        expo = 39'h0;
        for (int i = 1; i >= 0; i--)
        begin
            r = sh[{n, i[0]}];
            if (hit(r, x, f, d, n))
                expo = {1'b1, x, n ? r[6] : r[10], n ? r[6:5] : {2{r[10]}},
                    n && r[2] && (!d || m), n && e && r[9], n && e && r[8]};
        end
    endfunction : expo
    task acc(input logic [31:0] x, input logic [2:0] f, input logic d, m, n, e, p);
        logic [38:0] ex;
        ex = expo(x, f, d, m, n, e);
        a = x;
        fc = f;
        rw = d;
        rmw = m;
        nf = n;
        ext = e;
        pr = p;
        go = 1'b1;
        if (p && sup)
            sh[6] = ex[38] ? 32'h40 : 32'h0;
        @(negedge clk);
        pr = 1'b0;
        chk(64'({mt, phys, nc, pol, ab, p1, p0}), 64'(ex));
    endtask : acc
    initial
    begin
        logic [31:0] x;
        for (int i = 0; i < 8; i++)
            sh[i] = 32'h0;
        void'($urandom(51));
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 7; i++)
            rreg(abam_sel_t'(3'(i)));
        // user mode writes are refused
        sup = 1'b0;
        wreg(ABAM_SEL_OLD0, 32'hffff_ffff);
        wreg(ABAM_SEL_SRC, 32'h7);
        sup = 1'b1;
        rreg(ABAM_SEL_OLD0);
        wreg(ABAM_SEL_SRC, 32'h5);
        wreg(ABAM_SEL_DST, 32'hffff_fffa);
        chk(64'({srcc, dstc}), 64'({sh[4][2:0], sh[5][2:0]}));
        for (int i = 0; i < 4; i++)
        begin
            wreg(abam_sel_t'(3'(i)), cfg[i]);
            rreg(abam_sel_t'(3'(i)));
        end
        wreg(ABAM_SEL_STATUS, 32'hffff_ffff);
        // probe hit, then a user probe that must be ignored, then a miss
        acc(32'h1234_5678, 3'h5, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        rreg(ABAM_SEL_STATUS);
        sup = 1'b0;
        acc(32'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        sup = 1'b1;
        rreg(ABAM_SEL_STATUS);
        acc(32'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        rreg(ABAM_SEL_STATUS);
        // every cache policy on new1, then new1 switched off
        for (int p = 0; p < 5; p++)
        begin
            wreg(ABAM_SEL_NEW1, {8'hc0, 8'h00, p < 4, 2'b10, 3'h0, 2'b01, 1'b0, 2'(p), 5'h00});
            repeat (60)
            begin
                x = $urandom;
                if ($urandom % 5 != 0)
                    x[31:24] = tb[$urandom % 8];
                acc(x, 3'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
                    $urandom % 8 == 0);
            end
            go = 1'b0;
            rreg(ABAM_SEL_STATUS);
        end
        give_verdict;
    end
    // the run needs about 350 cycles
    initial
    begin
        #(8 * 5000);
        error_cnt++;
        give_verdict;
    end
endmodule : address_block_attr_match_bench
`default_nettype wire
